// file: led_pkg.sv
/*
 * Shared definitions for the slave status LED encoder: stack status and
 * APB request carriers, LED pattern codes, register map and pattern timing.
 * Assumes a single 125 MHz system clock; all times are in milliseconds.
 */
package led_pkg;

   // slave state machine as reported by the protocol stack
   typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP} slave_e;

   // what one LED half is showing
   typedef enum logic [2:0] {PAT_OFF, PAT_ON, PAT_BLINK, PAT_SINGLE, PAT_DOUBLE} pattern_e;

   typedef struct packed {
      slave_e state;
      logic   cfgErr;   // general configuration error
      logic   localErr; // state changed by the application on its own
      logic   wdErr;    // process data watchdog timeout
   } stack_s;

   localparam int ADDR_W = 12;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } apb_req_s;

   // register map
   localparam logic [ADDR_W-1:0] CTRL_ADDR   = 12'h000;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h004;
   localparam int CTRL_EN_BIT   = 0;
   localparam logic CTRL_EN_RESET = 1'b1;
   localparam int STAT_GREEN    = 0;
   localparam int STAT_RED      = 1;
   localparam int STAT_LA_LO    = 2;
   localparam int STAT_STATE_LO = 4;
   localparam int STAT_ERR_LO   = 6;

   // timing
   localparam int CLK_HZ      = 125_000_000;
   localparam int MS_PER_S    = 1000;
   localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;
   localparam int FLASH_MS    = 200;
   localparam int LONG_OFF_MS = 1000;
   localparam int FLICK_MS    = 50;
   localparam int BLINK_PERIOD_MS  = 2 * FLASH_MS;
   localparam int SINGLE_PERIOD_MS = FLASH_MS + LONG_OFF_MS;
   localparam int DOUBLE_PERIOD_MS = 3 * FLASH_MS + LONG_OFF_MS;
   localparam int MS_W = 11;
   localparam int PORTS = 2;

endpackage : led_pkg

// file: led_watch.sv
/* LED observer: lit and dark run lengths of one LED, in clocks.
   assumes the encoder clock and an active-high LED drive. */
`timescale 1ns/1ps
module led_watch (
   input  wire logic   clk,
   input  wire logic   rst,
   input  wire logic   led,
   output logic [31:0] onLen,
   output logic [31:0] offLen,
   output logic [31:0] prevOff
);
   logic [31:0] run;
   logic        last;
   // a run closes at each change; two dark runs kept for double flash
   always_ff @(posedge clk) begin
      if (rst) begin
         {run, onLen, offLen, prevOff, last} <= '0;
      end else begin
         last <= led;
         run  <= (led != last) ? 32'h1 : run + 32'h1;
         if (led != last && last) onLen <= run;
         if (led != last && !last) begin
            prevOff <= offLen;
            offLen  <= run;
         end
      end
   end
endmodule : led_watch

// file: slave_status_led_encoder.sv
/*
 * Slave status LED encoder: turns the slave state, its error flags and the
 * port link/activity indications into duo communication LED and port LED
 * drive, with a small APB register file for enable and status readback.
 * Assumes all inputs are synchronous to clk; LED outputs are active high.
 */
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps

module slave_status_led_encoder #(
   parameter int TICK_CYCLES = led_pkg::TICK_CYCLES,
   parameter int PORTS       = led_pkg::PORTS
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire led_pkg::stack_s   stack,
   input  wire logic [PORTS-1:0]  linkUp,
   input  wire logic [PORTS-1:0]  frameAct,
   input  wire led_pkg::apb_req_s apbReq,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   greenLed,
   output logic                   redLed,
   output logic [PORTS-1:0]       linkActLed,
   output logic [PORTS-1:0]       yellowLed
);

   localparam int TICK_W = $clog2(TICK_CYCLES + 1);
   localparam int FL_W   = $clog2(led_pkg::FLICK_MS + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
   localparam logic [led_pkg::MS_W-1:0] FLASH_END  = led_pkg::MS_W'(led_pkg::FLASH_MS);
   localparam logic [led_pkg::MS_W-1:0] FLASH2_BEG = led_pkg::MS_W'(2 * led_pkg::FLASH_MS);
   localparam logic [led_pkg::MS_W-1:0] FLASH2_END = led_pkg::MS_W'(3 * led_pkg::FLASH_MS);
   localparam logic [led_pkg::MS_W-1:0] BLINK_LAST =
      led_pkg::MS_W'(led_pkg::BLINK_PERIOD_MS - 1);
   localparam logic [led_pkg::MS_W-1:0] SINGLE_LAST =
      led_pkg::MS_W'(led_pkg::SINGLE_PERIOD_MS - 1);
   localparam logic [led_pkg::MS_W-1:0] DOUBLE_LAST =
      led_pkg::MS_W'(led_pkg::DOUBLE_PERIOD_MS - 1);
   localparam logic [FL_W-1:0] FLICK_LAST = FL_W'(led_pkg::FLICK_MS - 1);

   typedef struct packed {
      logic [TICK_W-1:0]             tickCnt;
      logic [led_pkg::MS_W-1:0]      blinkMs;
      logic [led_pkg::MS_W-1:0]      singleMs;
      logic [led_pkg::MS_W-1:0]      doubleMs;
      logic [PORTS-1:0]              actBusy;
      logic [PORTS-1:0]              actLit;
      logic [PORTS-1:0]              actPend;
      logic [PORTS-1:0][FL_W-1:0]    actMs;
      logic                          ctrlEn;
      logic [31:0]                   rdData;
      logic                          green;
      logic                          red;
      logic [PORTS-1:0]              linkAct;
   } state_s;

   state_s st;
   state_s next_st;
   logic   tick;
   logic   apbSetup;
   logic   apbAccess;
   logic   addrHit;
   led_pkg::pattern_e greenPat;
   led_pkg::pattern_e redPat;

   // whether a pattern is in a lit phase; each flashing pattern has its own ms counter, shared by both halves
   function automatic logic patLit(input led_pkg::pattern_e pat, input state_s s);
      logic lit;
      lit = 1'b0;
      unique case (pat)
         led_pkg::PAT_OFF:    lit = 1'b0;
         led_pkg::PAT_ON:     lit = 1'b1;
         led_pkg::PAT_BLINK:  lit = s.blinkMs < FLASH_END;
         led_pkg::PAT_SINGLE: lit = s.singleMs < FLASH_END;
         led_pkg::PAT_DOUBLE: lit = (s.doubleMs < FLASH_END) ||
                                    (s.doubleMs >= FLASH2_BEG && s.doubleMs < FLASH2_END);
         default:             lit = 1'b0;
      endcase
      return lit;
   endfunction : patLit

   function automatic logic isKnownAddr(input logic [led_pkg::ADDR_W-1:0] a);
      return (a == led_pkg::CTRL_ADDR) || (a == led_pkg::STATUS_ADDR);
   endfunction : isKnownAddr

   // bus phase decode; zero-wait access, read data latched in setup
   assign apbSetup  = apbReq.psel && !apbReq.penable;
   assign apbAccess = apbReq.psel && apbReq.penable;
   assign addrHit   = isKnownAddr(apbReq.paddr);
   assign pready    = apbAccess;
   assign pslverr   = apbAccess && !addrHit;
   assign tick      = st.tickCnt == TICK_LAST;

   // green follows the slave state, forced to single flash on cable loss outside INIT
   always_comb begin
      unique case (stack.state)
         led_pkg::ST_INIT:   greenPat = led_pkg::PAT_OFF;
         led_pkg::ST_PREOP:  greenPat = led_pkg::PAT_BLINK;
         led_pkg::ST_SAFEOP: greenPat = led_pkg::PAT_SINGLE;
         led_pkg::ST_OP:     greenPat = led_pkg::PAT_ON;
      endcase
      if (stack.state != led_pkg::ST_INIT && linkUp == '0) begin
         greenPat = led_pkg::PAT_SINGLE;
      end
   end

   // red chosen from error flags, most severe first; INIT keeps it dark
   always_comb begin
      redPat = led_pkg::PAT_OFF;
      if (stack.state == led_pkg::ST_INIT) begin
         redPat = led_pkg::PAT_OFF;
      end else if (stack.wdErr || linkUp == '0) begin
         redPat = led_pkg::PAT_DOUBLE;
      end else if (stack.localErr) begin
         redPat = led_pkg::PAT_SINGLE;
      end else if (stack.cfgErr) begin
         redPat = led_pkg::PAT_BLINK;
      end
   end

   // next-state logic for counters, activity stretchers, registers, LEDs
   always_comb begin
      next_st = st;

      // one ms tick drives every pattern counter so they stay aligned
      next_st.tickCnt = tick ? '0 : st.tickCnt + TICK_W'(1);
      if (tick) begin
         next_st.blinkMs  = (st.blinkMs == BLINK_LAST) ? '0
                            : st.blinkMs + led_pkg::MS_W'(1);
         next_st.singleMs = (st.singleMs == SINGLE_LAST) ? '0
                            : st.singleMs + led_pkg::MS_W'(1);
         next_st.doubleMs = (st.doubleMs == DOUBLE_LAST) ? '0
                            : st.doubleMs + led_pkg::MS_W'(1);
      end

      // per port: a frame starts a dark then lit 50 ms pair; frames
      // arriving meanwhile queue one more pair so traffic keeps flashing
      for (int p = 0; p < PORTS; p++) begin
         if (!linkUp[p]) begin
            next_st.actBusy[p] = 1'b0;
            next_st.actPend[p] = 1'b0;
            next_st.actLit[p]  = 1'b0;
            next_st.actMs[p]   = '0;
         end else begin
            if (st.actBusy[p] && tick) begin
               next_st.actMs[p] = st.actMs[p] + FL_W'(1);
               if (st.actMs[p] == FLICK_LAST) begin
                  next_st.actMs[p] = '0;
                  if (!st.actLit[p]) begin
                     next_st.actLit[p] = 1'b1;
                  end else begin
                     next_st.actLit[p]  = 1'b0;
                     next_st.actBusy[p] = st.actPend[p];
                     next_st.actPend[p] = 1'b0;
                  end
               end
            end
            if (frameAct[p]) begin
               // a new frame wins over the pending clear above
               // a pair ending this cycle with none queued lets the frame start a fresh one
               if (!next_st.actBusy[p]) begin
                  next_st.actBusy[p] = 1'b1;
                  next_st.actLit[p]  = 1'b0;
                  next_st.actMs[p]   = '0;
                  next_st.actPend[p] = 1'b0;
               end else begin
                  next_st.actPend[p] = 1'b1;
               end
            end
         end
         // steady with link, dark during the dark half of a flash
         next_st.linkAct[p] = st.ctrlEn && linkUp[p]
                              && (!st.actBusy[p] || st.actLit[p]);
      end

      // each half evaluated on its own so both can show at once
      next_st.green = st.ctrlEn && patLit(greenPat, st);
      next_st.red   = st.ctrlEn && patLit(redPat, st);

      // register writes take effect at the access edge
      if (apbAccess && apbReq.pwrite && apbReq.paddr == led_pkg::CTRL_ADDR) begin
         next_st.ctrlEn = apbReq.pwdata[led_pkg::CTRL_EN_BIT];
      end

      // read data captured in setup so it comes from a flop in access
      if (apbSetup) begin
         next_st.rdData = '0;
         if (apbReq.paddr == led_pkg::CTRL_ADDR) begin
            next_st.rdData[led_pkg::CTRL_EN_BIT] = st.ctrlEn;
         end else if (apbReq.paddr == led_pkg::STATUS_ADDR) begin
            next_st.rdData[led_pkg::STAT_GREEN] = st.green;
            next_st.rdData[led_pkg::STAT_RED]   = st.red;
            next_st.rdData[led_pkg::STAT_LA_LO +: PORTS] = st.linkAct;
            next_st.rdData[led_pkg::STAT_STATE_LO +: 2]  = stack.state;
            next_st.rdData[led_pkg::STAT_ERR_LO +: 3] =
               {stack.wdErr, stack.localErr, stack.cfgErr};
         end
      end
   end

   // state register; synchronous reset to all dark, LEDs enabled
   always_ff @(posedge clk) begin
      if (rst) begin
         st        <= '0;
         st.ctrlEn <= led_pkg::CTRL_EN_RESET;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from flops; yellow LEDs unused in this mode
   assign prdata     = st.rdData;
   assign greenLed   = st.green;
   assign redLed     = st.red;
   assign linkActLed = st.linkAct;
   assign yellowLed  = '0;

endmodule : slave_status_led_encoder

// file: slave_status_led_encoder_sva.sv
/* checker for the status LED encoder: port relations over time.
   assumes a bind to the encoder top; LEDs lag their inputs one clock. */
`timescale 1ns/1ps
module slave_status_led_encoder_sva #(
   parameter int TICK_CYCLES = 4,
   parameter int PORTS       = 2
) (
   input wire logic              clk,
   input wire logic              rst,
   input wire led_pkg::stack_s   stack,
   input wire logic [PORTS-1:0]  linkUp,
   input wire led_pkg::apb_req_s apbReq,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              greenLed,
   input wire logic              redLed,
   input wire logic [PORTS-1:0]  linkActLed,
   input wire logic [PORTS-1:0]  yellowLed
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   int redRun;
   // red lit run; every pattern's lit phase nests inside one flash
   always_ff @(posedge clk) begin
      redRun <= (rst || !redLed) ? 0 : redRun + 1;
   end
   AST_INIT: assert property (
      !$past(rst) && $past(stack.state) == led_pkg::ST_INIT |-> !greenLed && !redLed)
      else $error("duo lit in init");
   AST_OP: assert property (
      !$past(rst) && $past(stack.state) == led_pkg::ST_OP && $past(linkUp) != '0 |-> greenLed)
      else $error("green dark in op");
   AST_QUIET: assert property (
      !$past(rst) && $past(stack[2:0]) == 3'h0 && $past(linkUp) != '0 |-> !redLed)
      else $error("red lit without error");
   AST_REDMAX: assert property (redRun <= led_pkg::FLASH_MS * TICK_CYCLES)
      else $error("red lit too long");
   AST_LINK: assert property ((linkActLed & ~$past(linkUp)) == '0)
      else $error("link led lit without link");
   AST_YEL: assert property (yellowLed == '0)
      else $error("yellow led lit");
   AST_RDY: assert property (pready == (apbReq.psel && apbReq.penable))
      else $error("pready wrong");
   AST_ERR: assert property (pslverr == (pready && apbReq.paddr != led_pkg::CTRL_ADDR
      && apbReq.paddr != led_pkg::STATUS_ADDR))
      else $error("pslverr wrong");
endmodule : slave_status_led_encoder_sva

// file: tb_slave_status_led_encoder.sv
/* testbench for the status LED encoder: stack, link and APB stimulus.
   assumes the encoder, its checker and led_watch; 1 ms is 4 clocks. */
`timescale 1ns/1ps
module tb_slave_status_led_encoder;
   localparam int TICK = 4;
   localparam int FL   = led_pkg::FLASH_MS * TICK;
   localparam int LO   = led_pkg::LONG_OFF_MS * TICK;
   logic              clk, rst, pready, pslverr, greenLed, redLed, err;
   led_pkg::stack_s   stack;
   led_pkg::apb_req_s apbReq;
   logic [1:0]        linkUp, frameAct, linkActLed, yellowLed;
   logic [31:0]       prdata, rd, gOn, gOff, gPrev, rOn, rOff, rPrev;
   int                fail_count, check_count;
   slave_status_led_encoder #(.TICK_CYCLES(TICK)) slave_status_led_encoder_i (
      .clk(clk), .rst(rst), .stack(stack), .linkUp(linkUp), .frameAct(frameAct),
      .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .greenLed(greenLed), .redLed(redLed), .linkActLed(linkActLed), .yellowLed(yellowLed));
   led_watch led_watch_i (.clk(clk), .rst(rst), .led(greenLed), .onLen(gOn), .offLen(gOff),
      .prevOff(gPrev));
   led_watch led_watch_red_i (.clk(clk), .rst(rst), .led(redLed), .onLen(rOn), .offLen(rOff),
      .prevOff(rPrev));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic results;
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic setp(input led_pkg::slave_e s, input logic [2:0] e, input logic [1:0] l);
      @(posedge clk);
      stack  <= {s, e};
      linkUp <= l;
   endtask : setp
   // two full double-flash periods, so both watchers see only the new pattern
   task automatic pat(input led_pkg::slave_e s, input logic [2:0] e, input logic [1:0] l,
                      input int gO, input int gF, input int rO, input int rF);
      setp(s, e, l);
      repeat (14000) @(posedge clk);
      if (gO != 0) chk("green lit", gO, gOn);
      if (gO != 0) chk("green dark", gF, gOff + gPrev);
      chk("red lit", rO, rOn);
      chk("red dark", rF, rOff + rPrev);
   endtask : pat
   // zero-wait slave, but the wait stays bounded and never assumes it
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n = 0;
      @(posedge clk);
      apbReq <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) fail_count++;
      if (pready !== 1'b1) results();
      r = prdata;
      e = pslverr;
      apbReq <= '0;
   endtask : apb
   initial begin
      rst      = 1'b1;
      stack    = '0;
      linkUp   = 2'h0;
      frameAct = 2'h0;
      apbReq   = '0;
      {fail_count, check_count} = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      setp(led_pkg::ST_INIT, 3'h0, 2'h3);
      repeat (900) @(posedge clk);
      chk("duo init", 2'h0, {greenLed, redLed});
      chk("yellow dark", 2'h0, yellowLed);
      pat(led_pkg::ST_PREOP, 3'h4, 2'h3, FL, 2*FL, FL, 2*FL);
      pat(led_pkg::ST_SAFEOP, 3'h2, 2'h3, FL, 2*LO, FL, 2*LO);
      pat(led_pkg::ST_OP, 3'h1, 2'h3, 0, 0, FL, FL+LO);
      chk("green op", 1'b1, greenLed);
      pat(led_pkg::ST_OP, 3'h0, 2'h0, FL, 2*LO, FL, FL+LO);
      setp(led_pkg::ST_OP, 3'h0, 2'h3);
      repeat (10) @(posedge clk);
      frameAct <= 2'h1;
      @(posedge clk);
      frameAct <= 2'h0;
      repeat (180) @(posedge clk);
      chk("act dark", 2'h2, linkActLed);
      repeat (80) @(posedge clk);
      chk("act lit", 2'h3, linkActLed);
      setp(led_pkg::ST_INIT, 3'h0, 2'h3);
      repeat (3) @(posedge clk);
      apb(1'b0, led_pkg::STATUS_ADDR, 32'h0, rd, err);
      chk("status", 32'h0000000C, rd);
      apb(1'b0, led_pkg::CTRL_ADDR, 32'h0, rd, err);
      chk("ctrl", 32'h00000001, rd);
      apb(1'b1, led_pkg::CTRL_ADDR, 32'h0, rd, err);
      repeat (3) @(posedge clk);
      chk("ctrl off", 2'h0, linkActLed);
      apb(1'b0, 12'h008, 32'h0, rd, err);
      chk("unmapped err", 1'b1, err);
      chk("unmapped data", 32'h0, rd);
      apb(1'b1, led_pkg::CTRL_ADDR, 32'h1, rd, err);
      repeat (3) @(posedge clk);
      chk("ctrl on", 2'h3, linkActLed);
      results();
   end
endmodule : tb_slave_status_led_encoder

bind slave_status_led_encoder slave_status_led_encoder_sva #(.TICK_CYCLES(TICK_CYCLES),
   .PORTS(PORTS)) sva_i (.clk(clk), .rst(rst), .stack(stack), .linkUp(linkUp),
   .apbReq(apbReq), .pready(pready), .pslverr(pslverr), .greenLed(greenLed),
   .redLed(redLed), .linkActLed(linkActLed), .yellowLed(yellowLed));
